// File: logic/ttl_pkg.sv
// Package of constants for the thermal trip latch.
package ttl_pkg;
  // ==========================================================================
  // Sensor and reset values
  // ==========================================================================
  localparam int       TRIP_TEMP_C     = 135;
  localparam logic     TRIP_RST_VAL    = 1'b0;
  localparam logic     SHDN_N_INACTIVE = 1'b1;
  localparam logic     SHDN_N_ACTIVE   = 1'b0;
  localparam int       SYNC_STAGES     = 2;
  localparam int       VEC_W           = 32;
  localparam logic [31:0] BOOT_VEC_DFLT = 32'h0000_0000;
  typedef enum logic [1:0] {TTL_RUN, TTL_TRIPPED} ttl_state_t;
endpackage

// File: logic/ttl_thermal_trip_latch.sv
// Over-temperature trip latch with clock halt and boot restart.
`timescale 1ns/1ns
module ttl_thermal_trip_latch #(
  parameter logic [ttl_pkg::VEC_W-1:0] BOOT_VEC = ttl_pkg::BOOT_VEC_DFLT
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      resetn_i,
  input  wire logic                      sensor_trip_i,
  output logic                           overtemp_shutdown_n_o,
  output logic                           core_clk_en_o,
  output logic                           exec_halt_o,
  output logic                           boot_start_o,
  output logic [ttl_pkg::VEC_W-1:0]      boot_vec_o
);

  // ==========================================================================
  // Sensor synchroniser
  // ==========================================================================
  logic sync1_r;
  logic sync2_r;
  logic sync1_nxt;
  logic sync2_nxt;

  always_comb begin
    sync1_nxt = sensor_trip_i;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sync1_r <= ttl_pkg::TRIP_RST_VAL;
      sync2_r <= ttl_pkg::TRIP_RST_VAL;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // Only the second stage may feed the latch, since the first can settle late.
  a_sync_delay: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(sync2_r)
    |-> $past(sensor_trip_i, 2))
    else $error("synchroniser output rose without an earlier sensor trip");

  a_sync_cleared: assert property (@(posedge clk_sys_i)
    !resetn_i
    |=> !sync1_r && !sync2_r)
    else $error("reset left a stale sensor sample in the synchroniser");

  // ==========================================================================
  // Trip latch and outputs
  // ==========================================================================
  ttl_pkg::ttl_state_t state_r;
  ttl_pkg::ttl_state_t state_nxt;
  logic boot_pend_r;
  logic boot_pend_nxt;
  logic shdn_n_nxt;
  logic clk_en_nxt;
  logic halt_nxt;
  logic boot_nxt;

  always_comb begin
    state_nxt     = state_r;
    boot_pend_nxt = 1'b0;
    unique case (state_r)
      ttl_pkg::TTL_RUN: begin
        if (sync2_r) begin
          state_nxt = ttl_pkg::TTL_TRIPPED;
        end
      end
      ttl_pkg::TTL_TRIPPED: begin
        state_nxt = ttl_pkg::TTL_TRIPPED;
      end
      default: begin
        state_nxt = ttl_pkg::TTL_RUN;
      end
    endcase
    shdn_n_nxt = (state_nxt == ttl_pkg::TTL_TRIPPED) ? ttl_pkg::SHDN_N_ACTIVE
                                                     : ttl_pkg::SHDN_N_INACTIVE;
    clk_en_nxt = (state_nxt != ttl_pkg::TTL_TRIPPED);
    halt_nxt   = (state_nxt == ttl_pkg::TTL_TRIPPED);
    boot_nxt   = boot_pend_r;
  end

  // Reset forces the run state and arms one boot pulse at the first edge after release.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_r               <= ttl_pkg::TTL_RUN;
      boot_pend_r           <= 1'b1;
      overtemp_shutdown_n_o <= ttl_pkg::SHDN_N_INACTIVE;
      core_clk_en_o         <= 1'b1;
      exec_halt_o           <= 1'b0;
      boot_start_o          <= 1'b0;
      boot_vec_o            <= BOOT_VEC;
    end else begin
      state_r               <= state_nxt;
      boot_pend_r           <= boot_pend_nxt;
      overtemp_shutdown_n_o <= shdn_n_nxt;
      core_clk_en_o         <= clk_en_nxt;
      exec_halt_o           <= halt_nxt;
      boot_start_o          <= boot_nxt;
      boot_vec_o            <= BOOT_VEC;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_sensor_hit;
    sensor_trip_i && overtemp_shutdown_n_o;
  endsequence

  sequence s_tripped;
    !overtemp_shutdown_n_o && !core_clk_en_o && exec_halt_o;
  endsequence

  a_trip_latency: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_sensor_hit ##1 resetn_i [*3] |-> s_tripped)
    else $error("shutdown not asserted three cycles after sensor trip");

  a_trip_not_early: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $fell(overtemp_shutdown_n_o) |-> $past(sensor_trip_i, 3))
    else $error("shutdown asserted without a synchronised sensor trip");

  a_trip_halt_core: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (overtemp_shutdown_n_o == core_clk_en_o) && (exec_halt_o == !overtemp_shutdown_n_o))
    else $error("clock halt does not follow shutdown state");

  a_trip_held: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !overtemp_shutdown_n_o |=> !overtemp_shutdown_n_o)
    else $error("latched shutdown released without reset");

  // The next output follows the sensor two edges back, through the synchroniser.
  a_cold_stays_run: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    overtemp_shutdown_n_o && !$past(sensor_trip_i, 2)
    |=> overtemp_shutdown_n_o)
    else $error("shutdown asserted while the sensor was cold");

  a_cold_no_halt: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    core_clk_en_o && !$past(sensor_trip_i, 2)
    |=> core_clk_en_o && !exec_halt_o)
    else $error("core halted while the sensor was cold");

  a_clk_stop_held: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !core_clk_en_o
    |=> !core_clk_en_o)
    else $error("core clock restarted without reset");

  a_exec_halt_held: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    exec_halt_o
    |=> exec_halt_o)
    else $error("execution resumed without reset");

  sequence s_short_pulse;
    !sensor_trip_i ##1 sensor_trip_i ##1 !sensor_trip_i;
  endsequence

  // A sensor pulse of a single cycle must still set the latch.
  a_short_pulse_trips: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    overtemp_shutdown_n_o ##0 s_short_pulse ##1 resetn_i [*2]
    |-> !overtemp_shutdown_n_o)
    else $error("single cycle sensor pulse did not trip");

  a_reset_clears: assert property (@(posedge clk_sys_i)
    !resetn_i |=> overtemp_shutdown_n_o && core_clk_en_o && !exec_halt_o)
    else $error("reset did not clear the shutdown latch");

  // ==========================================================================
  // Reset and boot checks
  // ==========================================================================
  sequence s_reset_release;
    !resetn_i ##1 resetn_i;
  endsequence

  sequence s_boot_pulse;
    boot_start_o && boot_vec_o == BOOT_VEC ##1 !boot_start_o;
  endsequence

  a_boot_restart: assert property (@(posedge clk_sys_i)
    s_reset_release |=> s_boot_pulse)
    else $error("boot start pulse missing after reset");

  // A reset that lands while still hot clears the pin, and the part then trips again.
  a_hot_reset_clears: assert property (@(posedge clk_sys_i)
    !resetn_i && sensor_trip_i
    |=> overtemp_shutdown_n_o && core_clk_en_o)
    else $error("reset did not clear the shutdown while the sensor was hot");

  a_retrip_hot: assert property (@(posedge clk_sys_i)
    s_reset_release ##0 sensor_trip_i ##1 resetn_i [*3]
    |-> !overtemp_shutdown_n_o)
    else $error("hot sensor did not trip again after reset release");

  a_boot_single: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    boot_start_o
    |=> !boot_start_o)
    else $error("boot start pulse longer than one cycle");

  a_boot_after_reset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(boot_start_o)
    |-> !$past(resetn_i, 2))
    else $error("boot start pulse without a preceding reset");

  a_boot_no_spurious: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(resetn_i) && $past(resetn_i, 2)
    |-> !boot_start_o)
    else $error("boot start pulse in the middle of a run");

  a_boot_runs_core: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    boot_start_o
    |-> core_clk_en_o && !exec_halt_o && overtemp_shutdown_n_o)
    else $error("boot started while the core was still halted");

  a_boot_vec_fixed: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    boot_start_o || !boot_start_o
    |-> boot_vec_o == BOOT_VEC)
    else $error("boot vector differs from its parameter");

endmodule

// File: tb/ttl_power_model.sv
// Platform power control model that watches the shutdown output.
`timescale 1ns/1ns
module ttl_power_model (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic shdn_n_i,
  output logic      power_on_o
);
  // Supply stays off after a trip until the platform resets the part.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      power_on_o <= 1'b1;
    end else if (!shdn_n_i) begin
      power_on_o <= 1'b0;
    end
  end
endmodule

// File: tb/test_thermal_trip_latch.sv
// Self-checking bench for the thermal trip latch.
`timescale 1ns/1ns
module test_thermal_trip_latch;
  logic        clk_sys_i = 0, resetn_i = 0, sensor_trip_i = 0;
  logic        shdn_n, clk_en, halt, boot, pwr, prev_n = 1;
  logic [31:0] vec;
  int          cyc = 0, n_mismatch = 0, samples_checked = 0, k;
  int          q[$];
  initial forever #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  ttl_thermal_trip_latch #(.BOOT_VEC(32'h0000_0100)) uut (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .sensor_trip_i(sensor_trip_i), .overtemp_shutdown_n_o(shdn_n),
    .core_clk_en_o(clk_en), .exec_halt_o(halt), .boot_start_o(boot), .boot_vec_o(vec));
  ttl_power_model pm (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .shdn_n_i(shdn_n),
    .power_on_o(pwr));
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Notes hold the expected cycle: positive for a trip, negative for a boot pulse.
  always @(negedge clk_sys_i) begin
    if (boot === 1'b1) begin
      chk(q.size() > 0 && q[0] == -cyc && vec === 32'h0000_0100, "boot");
      if (q.size() > 0) void'(q.pop_front());
    end
    if (prev_n === 1'b1 && shdn_n === 1'b0) begin
      chk(q.size() > 0 && q[0] == cyc && clk_en === 1'b0 && halt === 1'b1, "trip");
      if (q.size() > 0) void'(q.pop_front());
    end
    prev_n = shdn_n;
  end
  task automatic trip_cycle(input logic hot);
    repeat (4) @(posedge clk_sys_i);
    sensor_trip_i <= 1'b1;
    q.push_back(cyc + 4);
    repeat ($urandom_range(4, 1)) @(posedge clk_sys_i);
    sensor_trip_i <= hot;
    repeat (12) @(posedge clk_sys_i);
    chk(shdn_n === 1'b0 && pwr === 1'b0, "latch lost");
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk(shdn_n === 1'b1 && clk_en === 1'b1 && halt === 1'b0, "not cleared");
    resetn_i <= 1'b1;
    q.push_back(-(cyc + 2));
    if (hot) q.push_back(cyc + 4);
  endtask
  initial begin
    k = $urandom(32'h529d7843);
    repeat (6) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    q.push_back(-(cyc + 2));
    repeat (3) trip_cycle(1'b0);
    trip_cycle(1'b1);
    repeat (10) @(posedge clk_sys_i);
    chk(q.size() == 0, "missing event");
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    n_mismatch++;
    end_sim();
  end
endmodule
